// ### src/peoa_core.sv
`timescale 1ns/1ps
// Operation
// - First threshold is the peak sub-sub-block energy divided by eight.
// - Onset in look-ahead memory: examine one sub-block of memory samples only.
// - Later-index threshold: max(noise, (reference + 4*preceding sum)/(j+1)).
// - Reference is prior energy times gain, or peak/80 if larger and crossings high.
// - Onset starts at first non-echo sub-block, advancing per quiet sub-sub-block.
// - Moved samples take the last echo-zone gain in each band.
// - Onset in first or second sub-block: skip regression check.
// - Onset in third sub-block: inhibit if high-band energy falls.
// - Later onset: inhibit if full-band energy falls over three sub-blocks.
// - Later onset: inhibit if high-band slope under two fifteenths of sum.
// - Low-band gain steps ramp with 20 levels narrowband, else 4.
// - Ramp at each sub-block start and onset; first from stored last gain.
// - Onset in next frame: no ramp at frame end, deferred to next frame.
// - High-band gain applied directly, never smoothed.
// - Output is the sum of both gain-scaled band samples.
// - Sub-block splits into 4 sub-sub-blocks at 8 kHz, else 8.
// - Crossing limit is 10 narrowband, 16 otherwise.
module peoa_core (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  input  wire logic                                  frame_valid,
  input  wire peoa_pkg::peoa_frame_t                 frame,
  input  wire peoa_pkg::peoa_samp_t                  rd_data,
  output logic [peoa_pkg::ADDR_W-1:0]                rd_addr,
  output logic                                       rd_en,
  output logic signed [peoa_pkg::SAMP_W:0]           out_sample,
  output logic                                       out_valid,
  output logic                                       done
);
  localparam int EW = peoa_pkg::E_W;
  localparam int CW = EW + 9;
  localparam int GW = peoa_pkg::G_W;
  localparam int AW = peoa_pkg::ADDR_W;

  peoa_pkg::peoa_core_t s;
  peoa_pkg::peoa_core_t n;
  logic                 inhibit;
  logic [3:0]           idx;
  logic                 in_mem;
  logic [6:0]           n_ssf;
  logic [3:0]           ssf_len;
  logic [6:0]           num_ssf;
  logic [AW-1:0]        start;
  logic [AW-1:0]        reg_len;
  logic [peoa_pkg::ZCR_W-1:0] zcr_lim;
  logic [4:0]           smooth;
  logic [EW-1:0]        mcrit;
  logic [EW-1:0]        mcrit_alt;
  logic [EW+GW-1:0]     mcrit_prod;
  logic [EW-1:0]        ref_lvl;
  logic [EW-1:0]        thr1;
  logic [EW-1:0]        cur_e;
  logic [CW-1:0]        lhs;
  logic [CW-1:0]        rhs;
  logic                 below;
  logic [AW-1:0]        onset_pos;
  logic [3:0]           osb;
  logic [GW-1:0]        tgt_lb;
  logic [GW-1:0]        tgt_hb;
  logic                 change;
  logic [GW-1:0]        from;
  logic [4:0]           k;
  logic [21:0]          mix;
  logic [GW-1:0]        g_lb;
  logic [GW-1:0]        g_hb;
  logic [21:0]          mix_div;
  logic                 ramp_act;
  logic [EW-1:0]        e_new;
  logic [AW-1:0]        pos;
  logic [AW-1:0]        sb_off;
  logic signed [peoa_pkg::SAMP_W:0]     x_full;
  logic signed [2*peoa_pkg::SAMP_W+1:0] x_sq;
  logic signed [2*peoa_pkg::SAMP_W:0]   p_lb;
  logic signed [2*peoa_pkg::SAMP_W:0]   p_hb;
  logic signed [2*peoa_pkg::SAMP_W:0]   sum_w;

  localparam int SSW = EW + 6;
  localparam int SMW = peoa_pkg::SAMP_W;
  localparam int ZW  = peoa_pkg::ZCR_W;

  peoa_regress u_peoa_regress (
    .ref_clk (ref_clk),
    .rst     (rst),
    .frame   (frame),
    .inhibit (inhibit)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Frame configuration
    idx    = frame.first_non_echo_index;
    in_mem = idx >= 4'(peoa_pkg::N_SF);
    n_ssf  = frame.rate_8k ? 7'(peoa_pkg::N_SSF_NB) : 7'(peoa_pkg::N_SSF_WB);
    if (frame.rate_8k) begin
      ssf_len = 4'(peoa_pkg::SUB_LEN / peoa_pkg::N_SSF_NB);
    end else begin
      ssf_len = 4'(peoa_pkg::SUB_LEN / peoa_pkg::N_SSF_WB);
    end
    zcr_lim = frame.narrowband ? ZW'(peoa_pkg::ZCR_LIM_NB) : ZW'(peoa_pkg::ZCR_LIM_WB);
    smooth  = frame.narrowband ? 5'(peoa_pkg::SMOOTH_NB) : 5'(peoa_pkg::SMOOTH_WB);
    if (idx == 4'h0 || in_mem) begin
      num_ssf = n_ssf;
    end else begin
      num_ssf = 7'((peoa_pkg::N_SF - int'(idx)) * int'(n_ssf));
    end
    start   = in_mem ? AW'(peoa_pkg::FRAME_LEN) : AW'(int'(idx) * peoa_pkg::SUB_LEN);
    reg_len = AW'(int'(num_ssf) * int'(ssf_len));
    // Reference level of the running-mean threshold
    mcrit_prod = frame.es[3'(idx - 4'h1)] * frame.g_lb[3'(idx - 4'h1)];
    mcrit      = mcrit_prod[peoa_pkg::G_FRAC +: EW];
    mcrit_alt  = frame.es_max / EW'(peoa_pkg::MAXES_DIV);
    if (mcrit_alt > mcrit && frame.zcr_onset > zcr_lim) begin
      mcrit = mcrit_alt;
    end
    ref_lvl = (idx == 4'h0) ? frame.prior_noise_energy : mcrit;
    // No divider: e < (ref + 4*sum)/(j+1) becomes (e+1)*(j+1) <= ref + 4*sum
    cur_e     = s.sub_sub_block_energy[6'(s.j)];
    thr1      = s.ssb_max >> peoa_pkg::PEAK_SHIFT;
    lhs       = (CW'(cur_e) + CW'(1)) * CW'(s.j + 7'h1);
    rhs       = CW'(ref_lvl) + (CW'(s.ssum) << peoa_pkg::RUN_SHIFT);
    below     = (cur_e < thr1) && ((lhs <= rhs) || (cur_e < frame.prior_noise_energy));
    onset_pos = start + AW'(int'(s.adv) * int'(ssf_len));
    // Energy of the full signal
    x_full = {rd_data.lb[SMW-1], rd_data.lb} + {rd_data.hb[SMW-1], rd_data.hb};
    x_sq   = x_full * x_full;
    e_new  = s.acc + EW'($unsigned(x_sq));
    // Gains of the sample now arriving
    pos    = s.recv;
    osb    = 4'(int'(pos) / peoa_pkg::SUB_LEN);
    sb_off = AW'(int'(pos) % peoa_pkg::SUB_LEN);
    tgt_lb = frame.g_lb[3'(osb)];
    tgt_hb = frame.high_band_gain[3'(osb)];
    if (!in_mem && idx != 4'h0 && osb >= idx && pos < onset_pos) begin
      // Moved samples extend the last echo-zone sub-block
      tgt_lb = frame.g_lb[3'(idx - 4'h1)];
      tgt_hb = frame.high_band_gain[3'(idx - 4'h1)];
    end
    if (inhibit) begin
      tgt_lb = peoa_pkg::GAIN_UNITY;
      tgt_hb = peoa_pkg::GAIN_UNITY;
    end
    // Ramps start only at sub-block starts and the onset; a later onset ramps next frame
    change   = (sb_off == '0 || pos == onset_pos) && tgt_lb != s.last_lb;
    from     = change ? s.last_lb : s.ramp_from;
    k        = change ? 5'h1 : s.ramp_k;
    ramp_act = change || s.ramp_on;
    mix      = 22'(from) * 22'(smooth + 5'h1 - k) + 22'(tgt_lb) * 22'(k);
    if (frame.narrowband) begin
      mix_div = mix / 22'(peoa_pkg::SMOOTH_NB + 1);
    end else begin
      mix_div = mix / 22'(peoa_pkg::SMOOTH_WB + 1);
    end
    g_lb  = ramp_act ? mix_div[GW-1:0] : tgt_lb;
    g_hb  = tgt_hb;
    p_lb  = rd_data.lb * $signed({1'b0, g_lb});
    p_hb  = rd_data.hb * $signed({1'b0, g_hb});
    sum_w = (p_lb >>> peoa_pkg::G_FRAC) + (p_hb >>> peoa_pkg::G_FRAC);

    n           = s;
    n.rd_en     = 1'b0;
    n.rd_pend   = s.rd_en;
    n.out_valid = 1'b0;
    n.done      = 1'b0;
    unique case (s.st)
      peoa_pkg::ST_IDLE: begin
        if (frame_valid) begin
          n.st      = peoa_pkg::ST_ENERGY;
          n.issue   = '0;
          n.recv    = '0;
          n.j       = '0;
          n.wpos    = '0;
          n.acc     = '0;
          n.ssb_max = '0;
        end
      end
      peoa_pkg::ST_ENERGY: begin
        if (s.issue < reg_len) begin
          n.rd_en   = 1'b1;
          n.rd_addr = start + s.issue;
          n.issue   = s.issue + 1'b1;
        end
        if (s.rd_pend) begin
          n.recv = s.recv + 1'b1;
          if (s.wpos == ssf_len - 4'h1) begin
            n.sub_sub_block_energy[6'(s.j)] = e_new;
            if (e_new > s.ssb_max) begin
              n.ssb_max = e_new;
            end
            n.j    = s.j + 7'h1;
            n.acc  = '0;
            n.wpos = '0;
          end else begin
            n.acc  = e_new;
            n.wpos = s.wpos + 4'h1;
          end
          if (s.recv == reg_len - 1'b1) begin
            n.st   = peoa_pkg::ST_SCAN;
            n.j    = '0;
            n.ssum = '0;
            n.adv  = '0;
          end
        end
      end
      peoa_pkg::ST_SCAN: begin
        if (s.j < num_ssf && below) begin
          n.adv  = s.adv + 7'h1;
          n.ssum = s.ssum + SSW'(cur_e);
          n.j    = s.j + 7'h1;
        end else begin
          n.st      = peoa_pkg::ST_APPLY;
          n.issue   = '0;
          n.recv    = '0;
          n.ramp_on = 1'b0;
          n.last_lb = s.prev_lb;
        end
      end
      peoa_pkg::ST_APPLY: begin
        if (s.issue < AW'(peoa_pkg::FRAME_LEN)) begin
          n.rd_en   = 1'b1;
          n.rd_addr = s.issue;
          n.issue   = s.issue + 1'b1;
        end
        if (s.rd_pend) begin
          n.out_sample = sum_w[SMW:0];
          n.out_valid  = 1'b1;
          n.recv       = s.recv + 1'b1;
          n.last_lb    = g_lb;
          n.ramp_from  = from;
          n.ramp_k     = k + 5'h1;
          n.ramp_on    = ramp_act && (k < smooth);
          if (s.recv == AW'(peoa_pkg::FRAME_LEN - 1)) begin
            n.st = peoa_pkg::ST_FINISH;
          end
        end
      end
      peoa_pkg::ST_FINISH: begin
        n.done    = 1'b1;
        n.prev_lb = s.last_lb;
        n.st      = peoa_pkg::ST_IDLE;
      end
      default: begin
        n.st = peoa_pkg::ST_IDLE;
      end
    endcase
  end

  // Stored gain starts at unity so the first frame does not ramp from nothing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.prev_lb <= peoa_pkg::GAIN_UNITY;
      s.last_lb <= peoa_pkg::GAIN_UNITY;
    end else begin
      s <= n;
    end
  end

  assign rd_addr    = s.rd_addr;
  assign rd_en      = s.rd_en;
  assign out_sample = s.out_sample;
  assign out_valid  = s.out_valid;
  assign done       = s.done;

  ////////////////////////////////////////////////////////////////////////////
  read_range_a: assert property (@(posedge ref_clk) disable iff (rst)
      rd_en |-> rd_addr < AW'(peoa_pkg::FRAME_LEN + peoa_pkg::SUB_LEN))
    else $error("read beyond look-ahead sub-block");
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      done |-> !out_valid ##1 !done)
    else $error("done not a single pulse after last sample");
  ramp_len_a: assert property (@(posedge ref_clk) disable iff (rst)
      s.ramp_on |-> s.ramp_k <= smooth)
    else $error("low band ramp longer than smoothing length");
  scan_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
      s.st == peoa_pkg::ST_SCAN && !below |=> s.st == peoa_pkg::ST_APPLY)
    else $error("onset scan did not stop at loud sub-sub-block");
  attn_out_c: cover property (@(posedge ref_clk) out_valid && !inhibit && s.last_lb != '0);
  ramp_run_c: cover property (@(posedge ref_clk) s.ramp_on);
endmodule

// ### common/peoa_pkg.sv
package peoa_pkg;

  localparam int N_SF        = 8;
  localparam int N_SSF_NB    = 4;
  localparam int N_SSF_WB    = 8;
  localparam int MAX_SSB     = N_SF * N_SSF_WB;
  localparam int SUB_LEN     = 40;
  localparam int FRAME_LEN   = N_SF * SUB_LEN;
  localparam int ADDR_W      = 9;
  localparam int SAMP_W      = 16;
  localparam int E_W         = 40;
  localparam int G_W         = 16;
  localparam int G_FRAC      = 15;
  localparam int ZCR_W       = 8;
  localparam int PEAK_SHIFT  = 3;
  localparam int RUN_SHIFT   = 2;
  localparam int MAXES_DIV   = 80;
  localparam int ZCR_LIM_NB  = 10;
  localparam int ZCR_LIM_WB  = 16;
  localparam int SMOOTH_NB   = 20;
  localparam int SMOOTH_WB   = 4;
  localparam int SLOPE_NUM   = 2;
  localparam int SLOPE_DEN   = 15;
  localparam logic [G_W-1:0] GAIN_UNITY = 16'h8000;

  typedef struct packed {
    logic signed [SAMP_W-1:0] lb;
    logic signed [SAMP_W-1:0] hb;
  } peoa_samp_t;

  typedef struct packed {
    logic [N_SF:0][E_W-1:0]   es;
    logic [N_SF-1:0][E_W-1:0] es_hb;
    logic [E_W-1:0]           es_max;
    logic [E_W-1:0]           prior_noise_energy;
    logic [N_SF-1:0][G_W-1:0] g_lb;
    logic [N_SF-1:0][G_W-1:0] high_band_gain;
    logic [ZCR_W-1:0]         zcr_onset;
    logic [3:0]               first_non_echo_index;
    logic                     narrowband;
    logic                     rate_8k;
  } peoa_frame_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ENERGY, ST_SCAN, ST_APPLY, ST_FINISH} peoa_state_t;

  typedef struct packed {
    logic inhibit;
  } peoa_regress_t;

  typedef struct packed {
    peoa_state_t               st;
    logic [ADDR_W-1:0]         issue;
    logic [ADDR_W-1:0]         rd_addr;
    logic                      rd_en;
    logic                      rd_pend;
    logic [ADDR_W-1:0]         recv;
    logic [6:0]                j;
    logic [3:0]                wpos;
    logic [E_W-1:0]            acc;
    logic [MAX_SSB-1:0][E_W-1:0] sub_sub_block_energy;
    logic [E_W-1:0]            ssb_max;
    logic [E_W+5:0]            ssum;
    logic [6:0]                adv;
    logic [G_W-1:0]            prev_lb;
    logic [G_W-1:0]            ramp_from;
    logic [4:0]                ramp_k;
    logic                      ramp_on;
    logic [G_W-1:0]            last_lb;
    logic signed [SAMP_W:0]    out_sample;
    logic                      out_valid;
    logic                      done;
  } peoa_core_t;

endpackage

// ### src/peoa_regress.sv
`timescale 1ns/1ps
module peoa_regress (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire peoa_pkg::peoa_frame_t frame,
  output logic                      inhibit
);
  localparam int SW = peoa_pkg::E_W + 6;

  peoa_pkg::peoa_regress_t s;
  peoa_pkg::peoa_regress_t n;
  logic [3:0]              id;
  logic [3:0]              i1;
  logic [3:0]              i2;
  logic [3:0]              i3;
  logic signed [SW-1:0]    high_slope_short;
  logic signed [SW-1:0]    full_slope;
  logic signed [SW-1:0]    d13;
  logic signed [SW-1:0]    sum3;
  logic                    high_slope_normalised_lo;

  always_comb begin
    id   = frame.first_non_echo_index;
    i1   = id - 4'h1;
    i2   = id - 4'h2;
    i3   = id - 4'h3;
    high_slope_short = $signed({6'h00, frame.es_hb[1]}) - $signed({6'h00, frame.es_hb[0]});
    full_slope = $signed({6'h00, frame.es[i1[2:0]]}) - $signed({6'h00, frame.es[i3[2:0]]});
    d13  = $signed({6'h00, frame.es_hb[i1[2:0]]}) - $signed({6'h00, frame.es_hb[i3[2:0]]});
    sum3 = $signed({6'h00, frame.es_hb[i1[2:0]]}) + $signed({6'h00, frame.es_hb[i2[2:0]]})
         + $signed({6'h00, frame.es_hb[i3[2:0]]});
    // Slope below two fifteenths of the sum without a divider: 15 * diff < 2 * sum
    high_slope_normalised_lo = (d13 * $signed(SW'(peoa_pkg::SLOPE_DEN)))
                             < (sum3 * $signed(SW'(peoa_pkg::SLOPE_NUM)));
    n = s;
    if (id < 4'h2) begin
      n.inhibit = 1'b0;
    end else if (id == 4'h2) begin
      n.inhibit = high_slope_short < 0;
    end else begin
      n.inhibit = (full_slope < 0) || high_slope_normalised_lo;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign inhibit = s.inhibit;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  no_check_early_a: assert property ($stable(frame) && id < 4'h2 |=> !inhibit)
    else $error("inhibit raised for onset in first two sub-blocks");
  hb_short_a: assert property ($stable(frame) && id == 4'h2
      && frame.es_hb[1] < frame.es_hb[0] |=> inhibit)
    else $error("high band fall before third sub-block not inhibited");
  full_fall_a: assert property ($stable(frame) && id > 4'h2
      && frame.es[i1[2:0]] < frame.es[i3[2:0]] |=> inhibit)
    else $error("full band fall not inhibited");
  hb_norm_a: assert property ($stable(frame) && id > 4'h2
      && frame.es[i1[2:0]] >= frame.es[i3[2:0]]
      |=> inhibit == $past(high_slope_normalised_lo))
    else $error("normalised high band slope test wrong");
  inhibit_cover_c: cover property (id > 4'h2 ##1 inhibit);
endmodule

// ### verification/peoa_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module peoa_src (
  input  wire logic                        ref_clk,
  input  wire logic                        rd_en,
  input  wire logic [peoa_pkg::ADDR_W-1:0] rd_addr,
  output peoa_pkg::peoa_samp_t             rd_data = '0
);
  // Constant samples keep every expected sum exact
  always @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= '{lb: 16'sh0100, hb: 16'sh0080};
    end else begin
      // Not read: inverse so stale data cannot pass for fresh
      rd_data <= ~rd_data;
    end
  end
endmodule

// ### verification/pre_echo_onset_attenuator_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pre_echo_onset_attenuator_tb;
  logic                              ref_clk     = 1'b0;
  logic                              rst         = 1'b1;
  logic                              frame_valid = 1'b0;
  peoa_pkg::peoa_frame_t             fr          = '0;
  peoa_pkg::peoa_samp_t              rd_data;
  logic [peoa_pkg::ADDR_W-1:0]       rd_addr;
  logic                              rd_en;
  logic                              out_valid;
  logic                              done;
  logic signed [peoa_pkg::SAMP_W:0]  out_sample;
  int                                num_errors  = 0;
  int                                n_tests     = 0;

  always #2.5 ref_clk = ~ref_clk;

  peoa_core u_peoa_core (.ref_clk(ref_clk), .rst(rst), .frame_valid(frame_valid), .frame(fr),
    .rd_data(rd_data), .rd_addr(rd_addr), .rd_en(rd_en), .out_sample(out_sample),
    .out_valid(out_valid), .done(done));
  peoa_src u_peoa_src (.ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));

////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Unity gain everywhere: each output is lb plus hb
  task automatic run_frame(input int skip);
    int cnt;
    cnt = 0;
    @(negedge ref_clk) frame_valid = 1'b1;
    @(negedge ref_clk) frame_valid = 1'b0;
    for (int w = 0; w < 4000; w++) begin
      if (out_valid === 1'b1) begin
        if (cnt >= skip) check_val(out_sample, 17'h00180);
        cnt++;
      end
      if (done === 1'b1) break;
      @(negedge ref_clk);
    end
    check_val(17'(cnt), 17'(peoa_pkg::FRAME_LEN));
  endtask

  task automatic set_flat();
    for (int i = 0; i <= peoa_pkg::N_SF; i++) fr.es[i] = 40'h0000100000;
    for (int i = 0; i < peoa_pkg::N_SF; i++) begin
      fr.es_hb[i] = 40'h0000080000;
      fr.g_lb[i] = peoa_pkg::GAIN_UNITY;
      fr.high_band_gain[i] = peoa_pkg::GAIN_UNITY;
    end
    fr.es_max = 40'h0000100000;
    fr.first_non_echo_index = 4'h0;
  endtask

  // First frame starts from the unity stored gain set at reset; its first sub-block is still skipped
  task automatic flat_frames();
    set_flat();
    run_frame(peoa_pkg::SUB_LEN);
    run_frame(0);
  endtask

  // Falling energy, or a flat high band before a later onset, must leave the frame unattenuated
  task automatic inhibit_cases();
    for (int c = 0; c < 3; c++) begin
      set_flat();
      fr.first_non_echo_index = (c == 0) ? 4'h2 : 4'h4;
      for (int i = 0; i < fr.first_non_echo_index; i++) begin
        fr.g_lb[i] = 16'h0CCD;
        fr.high_band_gain[i] = 16'h0CCD;
      end
      if (c == 0) fr.es_hb[1] = 40'h0000000010;
      if (c == 1) fr.es[3] = 40'h0000000010;
      run_frame(0);
    end
  endtask

  // Onset in third sub-block, flat energy: first two sub-blocks stay attenuated
  task automatic attenuated_frame();
    int cnt;
    int gh;
    int gl;
    int lo;
    int one;
    cnt = 0;
    lo  = 32'h00000CCD;
    one = 32'h00008000;
    set_flat();
    fr.first_non_echo_index = 4'h2;
    for (int i = 0; i < 2; i++) begin
      fr.g_lb[i]           = 16'h0CCD;
      fr.high_band_gain[i] = 16'h0CCD;
    end
    @(negedge ref_clk) frame_valid = 1'b1;
    @(negedge ref_clk) frame_valid = 1'b0;
    for (int w = 0; w < 4000 && done !== 1'b1; w++) begin
      if (out_valid === 1'b1) begin
        gh = (cnt < 80) ? lo : one;
        gl = gh;
        if (cnt < 4) gl = (one * (4 - cnt) + lo * (cnt + 1)) / 5;
        if (cnt >= 80 && cnt < 84) gl = (lo * (84 - cnt) + one * (cnt - 79)) / 5;
        check_val(out_sample, 17'((256 * gl) / one + (128 * gh) / one));
        cnt++;
      end
      @(negedge ref_clk);
    end
    check_val(17'(cnt), 17'(peoa_pkg::FRAME_LEN));
  endtask

////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Six frames of a few hundred cycles each, with wide margin
  initial begin
    #100000;
    num_errors++;
    conclude();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    flat_frames();
    inhibit_cases();
    attenuated_frame();
    conclude();
  end
endmodule
